// ==== rtl/chg_stat_pkg.sv ====
// shared constants of the charger status and fault register bank
package chg_stat_pkg;
   // register offsets
   localparam logic [7:0] OFS_STATUS_THREE = 8'h1E;
   localparam logic [7:0] OFS_STATUS_FOUR = 8'h1F;
   localparam logic [7:0] OFS_FAULT_ZERO = 8'h20;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
   // reserved bit masks, these read as zero
   localparam logic [7:0] RSVD_STATUS_THREE = 8'h01;
   localparam logic [7:0] RSVD_STATUS_FOUR = 8'hE0;
   // field positions, charger status three
   localparam int B3_FET2 = 7;
   localparam int B3_FET1 = 6;
   localparam int B3_ADC = 5;
   localparam int B3_FLOOR = 4;
   localparam int B3_FAST = 3;
   localparam int B3_TRICKLE = 2;
   localparam int B3_PRE = 1;
   // field positions, charger status four
   localparam int B4_OTG_LOW = 4;
   localparam int B4_COLD = 3;
   localparam int B4_COOL = 2;
   localparam int B4_WARM = 1;
   localparam int B4_HOT = 0;
   // number of condition inputs packed into cond_raw, and synchroniser depth
   localparam int COND_W = 21;
   localparam int SYNC_STAGES = 2;
   // cycles from a condition pin to its register bit
   localparam int COND_LATENCY = 3;
   // target address of the serial port; value is arbitrary
   localparam logic [6:0] TARGET_ADDR = 7'h2A;
endpackage

// ==== rtl/cond_sync.sv ====
// two-flop synchroniser for a vector of unrelated level inputs
`timescale 1ns/1ps
module cond_sync
   import chg_stat_pkg::*;
#(
   parameter int WIDTH = COND_W,
   parameter int STAGES = SYNC_STAGES
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic reset_in,
   // levels
   input wire logic [WIDTH-1:0] level_in,
   output logic [WIDTH-1:0] level_out
);
   logic [WIDTH-1:0] stage_q [STAGES];

   if (STAGES < 2) begin : g_chk
      $error("cond_sync needs at least two stages");
   end

   // each bit is an independent level, so no bus coherence is needed
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         for (int i = 0; i < STAGES; i++) begin
            stage_q[i] <= '0;
         end
      end else begin
         stage_q[0] <= level_in;
         for (int i = 1; i < STAGES; i++) begin
            stage_q[i] <= stage_q[i-1];
         end
      end
   end

   assign level_out = stage_q[STAGES-1];
endmodule

// ==== rtl/reg_read_mux.sv ====
// read decode of the three status registers
`timescale 1ns/1ps
module reg_read_mux
   import chg_stat_pkg::*;
(
   // register pointer
   input wire logic [7:0] ptr_in,
   // register contents
   input wire logic [7:0] status3_in,
   input wire logic [7:0] status4_in,
   input wire logic [7:0] fault0_in,
   // selected byte
   output logic [7:0] rd_byte_out
);
   function automatic logic [7:0] pick(input logic [7:0] p, input logic [7:0] s3,
                                       input logic [7:0] s4, input logic [7:0] f0);
      logic [7:0] v;
      v = UNMAPPED_VALUE;
      unique case (p)
         OFS_STATUS_THREE: v = s3 & ~RSVD_STATUS_THREE;
         OFS_STATUS_FOUR: v = s4 & ~RSVD_STATUS_FOUR;
         OFS_FAULT_ZERO: v = f0;
         default: v = UNMAPPED_VALUE;
      endcase
      return v;
   endfunction

   assign rd_byte_out = pick(ptr_in, status3_in, status4_in, fault0_in);
endmodule

// ==== rtl/charger_status_fault_regs.sv ====
// charger status and fault register bank behind a serial target port
// Functional notes
// - three byte registers, read-only, reset to zero
// - status3 bit7: second input FET pair fitted
// - status3 bit6: first input FET pair fitted
// - status3 bit5: one-shot conversion complete
// - status3 bit4: forward mode, system floor regulating
// - status3 bits3..1: fast, trickle, pre timers expired
// - status4 bit4: battery too low for source
// - status4 bits3,2: thermistor cold, cool zones
// - status4 bits1,0: thermistor warm, hot zones
// - fault bit7: discharge current limiting
// - fault bit6: bus over-voltage protection
// - fault bit5: battery over-voltage protection
// - fault bits4,3: input, battery over-current
// - fault bit2: converter over-current protection
// - fault bits1,0: adapter2, adapter1 over-voltage
`timescale 1ns/1ps
module charger_status_fault_regs
   import chg_stat_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = TARGET_ADDR
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic reset_in,
   // serial register port, open drain data
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n_out,
   // board population and converter conditions
   input wire logic input2_blocking_fet_present_in,
   input wire logic input1_blocking_fet_present_in,
   input wire logic adc_conversion_done_in,
   input wire logic adc_one_shot_mode_in,
   input wire logic forward_mode_in,
   input wire logic system_floor_regulating_in,
   input wire logic fast_charge_timer_expired_in,
   input wire logic trickle_timer_expired_in,
   input wire logic precharge_timer_expired_in,
   // battery and thermistor conditions
   input wire logic battery_too_low_for_source_in,
   input wire logic thermistor_cold_zone_in,
   input wire logic thermistor_cool_zone_in,
   input wire logic thermistor_warm_zone_in,
   input wire logic thermistor_hot_zone_in,
   // protection conditions
   input wire logic discharge_current_limiting_in,
   input wire logic bus_overvoltage_fault_in,
   input wire logic battery_overvoltage_fault_in,
   input wire logic input_overcurrent_fault_in,
   input wire logic battery_overcurrent_fault_in,
   input wire logic converter_overcurrent_fault_in,
   input wire logic adapter2_overvoltage_fault_in,
   input wire logic adapter1_overvoltage_fault_in
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK, ST_RD_BYTE, ST_RD_ACK
   } port_state_t;

   logic [COND_W-1:0] cond_raw;
   logic [COND_W-1:0] cond_s;
   logic [1:0] pin_s;
   logic scl_s, sda_s, scl_p_q, sda_p_q;
   logic scl_rise, scl_fall, start_c, stop_c;
   logic [7:0] status3_q, status4_q, fault0_q;
   logic [7:0] rd_byte;
   port_state_t state_q, state_d;
   logic [2:0] bit_cnt_q, bit_cnt_d;
   logic [7:0] shift_q, shift_d;
   logic [7:0] ptr_q, ptr_d;
   logic byte_done_q, byte_done_d;
   logic rw_q, rw_d;
   logic ptr_phase_q, ptr_phase_d;
   logic master_ack_q, master_ack_d;
   logic drive_d;
   logic sda_oe_n_q;
   logic [1:0] rst_age_q;

   assign cond_raw = {input2_blocking_fet_present_in, input1_blocking_fet_present_in,
                      adc_conversion_done_in, adc_one_shot_mode_in, forward_mode_in,
                      system_floor_regulating_in, fast_charge_timer_expired_in,
                      trickle_timer_expired_in, precharge_timer_expired_in,
                      battery_too_low_for_source_in, thermistor_cold_zone_in,
                      thermistor_cool_zone_in, thermistor_warm_zone_in,
                      thermistor_hot_zone_in, discharge_current_limiting_in,
                      bus_overvoltage_fault_in, battery_overvoltage_fault_in,
                      input_overcurrent_fault_in, battery_overcurrent_fault_in,
                      converter_overcurrent_fault_in, adapter2_overvoltage_fault_in};

   // condition pins come from analog circuits, hence synchronised
   cond_sync #(.WIDTH(COND_W), .STAGES(SYNC_STAGES)) u_cond_sync (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .level_in(cond_raw),
      .level_out(cond_s)
   );

   // pins pass inverted so a cleared synchroniser reads as an idle high line
   cond_sync #(.WIDTH(2), .STAGES(SYNC_STAGES)) u_pin_sync (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .level_in({~scl_in, ~sda_in}),
      .level_out(pin_s)
   );

   // adapter1 fault has its own two-flop synchroniser so cond_raw stays a 21-bit pack
   logic [1:0] a1_sync_q;
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         a1_sync_q <= 2'h0;
      end else begin
         a1_sync_q <= {a1_sync_q[0], adapter1_overvoltage_fault_in};
      end
   end

   assign scl_s = ~pin_s[1];
   assign sda_s = ~pin_s[0];

   // status registers follow the synchronised levels, no latching
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         status3_q <= REG_RESET;
         status4_q <= REG_RESET;
         fault0_q <= REG_RESET;
      end else begin
         status3_q[B3_FET2] <= cond_s[20];
         status3_q[B3_FET1] <= cond_s[19];
         status3_q[B3_ADC] <= cond_s[18] & cond_s[17];
         status3_q[B3_FLOOR] <= cond_s[16] & cond_s[15];
         status3_q[B3_FAST] <= cond_s[14];
         status3_q[B3_TRICKLE] <= cond_s[13];
         status3_q[B3_PRE] <= cond_s[12];
         status3_q[0] <= 1'b0;
         status4_q[7:5] <= 3'h0;
         status4_q[B4_OTG_LOW] <= cond_s[11];
         status4_q[B4_COLD] <= cond_s[10];
         status4_q[B4_COOL] <= cond_s[9];
         status4_q[B4_WARM] <= cond_s[8];
         status4_q[B4_HOT] <= cond_s[7];
         fault0_q <= {cond_s[6:0], a1_sync_q[1]};
      end
   end

   reg_read_mux u_read_mux (
      .ptr_in(ptr_q),
      .status3_in(status3_q),
      .status4_in(status4_q),
      .fault0_in(fault0_q),
      .rd_byte_out(rd_byte)
   );

   // line edge detection on the synchronised copies
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_p_q;
   assign scl_fall = ~scl_s & scl_p_q;
   assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;

   always_comb begin
      state_d = state_q;
      bit_cnt_d = bit_cnt_q;
      shift_d = shift_q;
      ptr_d = ptr_q;
      byte_done_d = byte_done_q;
      rw_d = rw_q;
      ptr_phase_d = ptr_phase_q;
      master_ack_d = master_ack_q;
      if (start_c) begin
         // a repeated start keeps the pointer for a following read
         state_d = ST_ADDR;
         bit_cnt_d = 3'h0;
         byte_done_d = 1'b0;
      end else if (stop_c) begin
         state_d = ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
            end
            ST_ADDR, ST_WR_BYTE: begin
               if (scl_rise && !byte_done_q) begin
                  shift_d = {shift_q[6:0], sda_s};
                  bit_cnt_d = bit_cnt_q + 3'h1;
                  byte_done_d = (bit_cnt_q == 3'h7);
               end else if (scl_fall && byte_done_q) begin
                  byte_done_d = 1'b0;
                  if (state_q == ST_ADDR) begin
                     rw_d = shift_q[0];
                     ptr_phase_d = 1'b1;
                     state_d = (shift_q[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
                  end else begin
                     // data bytes are acknowledged and dropped
                     if (ptr_phase_q) begin
                        ptr_d = shift_q;
                     end
                     ptr_phase_d = 1'b0;
                     state_d = ST_WR_ACK;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  bit_cnt_d = 3'h0;
                  if (rw_q) begin
                     // byte frozen until its eight bits are sent; the next byte is loaded in ST_RD_ACK
                     shift_d = rd_byte;
                     state_d = ST_RD_BYTE;
                  end else begin
                     state_d = ST_WR_BYTE;
                  end
               end
            end
            ST_WR_ACK: begin
               if (scl_fall) begin
                  bit_cnt_d = 3'h0;
                  state_d = ST_WR_BYTE;
               end
            end
            ST_RD_BYTE: begin
               if (scl_fall) begin
                  if (bit_cnt_q == 3'h7) begin
                     ptr_d = ptr_q + 8'h01;
                     state_d = ST_RD_ACK;
                  end else begin
                     shift_d = {shift_q[6:0], 1'b0};
                     bit_cnt_d = bit_cnt_q + 3'h1;
                  end
               end
            end
            ST_RD_ACK: begin
               if (scl_rise) begin
                  master_ack_d = ~sda_s;
               end else if (scl_fall) begin
                  bit_cnt_d = 3'h0;
                  shift_d = rd_byte;
                  state_d = master_ack_q ? ST_RD_BYTE : ST_IDLE;
               end
            end
            default: state_d = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         state_q <= ST_IDLE;
         bit_cnt_q <= 3'h0;
         shift_q <= 8'h00;
         ptr_q <= 8'h00;
         byte_done_q <= 1'b0;
         rw_q <= 1'b0;
         ptr_phase_q <= 1'b0;
         master_ack_q <= 1'b0;
      end else begin
         state_q <= state_d;
         bit_cnt_q <= bit_cnt_d;
         shift_q <= shift_d;
         ptr_q <= ptr_d;
         byte_done_q <= byte_done_d;
         rw_q <= rw_d;
         ptr_phase_q <= ptr_phase_d;
         master_ack_q <= master_ack_d;
      end
   end

   // data only ever pulls low; a one is sent by releasing the line
   assign drive_d = (state_d == ST_ADDR_ACK) || (state_d == ST_WR_ACK) ||
                    ((state_d == ST_RD_BYTE) && !shift_d[7]);

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         sda_oe_n_q <= 1'b1;
      end else begin
         sda_oe_n_q <= ~drive_d;
      end
   end

   assign sda_oe_n_out = sda_oe_n_q;
   assign sda_out = 1'b0;

   // cycles since reset release, saturating, for the checks below
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         rst_age_q <= 2'h0;
      end else if (rst_age_q != 2'h3) begin
         rst_age_q <= rst_age_q + 2'h1;
      end
   end

   regs_reset_a: assert property (@(posedge mclk_in)
      reset_in |=> (status3_q == REG_RESET) && (status4_q == REG_RESET) && (fault0_q == REG_RESET))
      else $error("status registers not zero after reset");

   fets_follow_a: assert property (@(posedge mclk_in) disable iff (reset_in)
      (rst_age_q == 2'h3) |-> status3_q[7:6] ==
         {$past(input2_blocking_fet_present_in, 3), $past(input1_blocking_fet_present_in, 3)})
      else $error("fet population bits do not follow inputs");

   adc_done_a: assert property (@(posedge mclk_in) disable iff (reset_in)
      (rst_age_q == 2'h3) |-> status3_q[B3_ADC] ==
         ($past(adc_conversion_done_in, 3) && $past(adc_one_shot_mode_in, 3)))
      else $error("conversion done bit wrong");

   floor_reg_a: assert property (@(posedge mclk_in) disable iff (reset_in)
      (rst_age_q == 2'h3) |-> status3_q[B3_FLOOR] ==
         ($past(forward_mode_in, 3) && $past(system_floor_regulating_in, 3)))
      else $error("floor bit does not follow forward-mode regulation");

   timer_bits_a: assert property (@(posedge mclk_in) disable iff (reset_in)
      (rst_age_q == 2'h3) |-> status3_q[3:1] == {$past(fast_charge_timer_expired_in, 3),
         $past(trickle_timer_expired_in, 3), $past(precharge_timer_expired_in, 3)})
      else $error("timer bits do not follow inputs");

   thermistor_bits_a: assert property (@(posedge mclk_in) disable iff (reset_in)
      (rst_age_q == 2'h3) |-> status4_q[4:0] == {$past(battery_too_low_for_source_in, 3),
         $past(thermistor_cold_zone_in, 3), $past(thermistor_cool_zone_in, 3),
         $past(thermistor_warm_zone_in, 3), $past(thermistor_hot_zone_in, 3)})
      else $error("status four bits do not follow inputs");

   fault_bits_a: assert property (@(posedge mclk_in) disable iff (reset_in)
      (rst_age_q == 2'h3) |-> {fault0_q[7:6], fault0_q[1:0]} ==
         {$past(discharge_current_limiting_in, 3), $past(bus_overvoltage_fault_in, 3),
          $past(adapter2_overvoltage_fault_in, 3), $past(adapter1_overvoltage_fault_in, 3)})
      else $error("fault bits do not follow inputs");

   protect_bits_a: assert property (@(posedge mclk_in) disable iff (reset_in)
      (rst_age_q == 2'h3) |-> fault0_q[5:2] == {$past(battery_overvoltage_fault_in, 3),
         $past(input_overcurrent_fault_in, 3), $past(battery_overcurrent_fault_in, 3),
         $past(converter_overcurrent_fault_in, 3)})
      else $error("protection bits do not follow inputs");

   reserved_zero_a: assert property (@(posedge mclk_in) disable iff (reset_in)
      !status3_q[0] && (status4_q[7:5] == 3'h0))
      else $error("reserved bit reads one");

   read_load_a: assert property (@(posedge mclk_in) disable iff (reset_in)
      (state_q == ST_ADDR_ACK) && scl_fall && rw_q |=> (shift_q == $past(rd_byte)) ##1
         (sda_oe_n_out == shift_q[7]))
      else $error("read byte not loaded from register");
endmodule

// ==== verification/i2c_host_model.sv ====
// host processor model that reads the status bank over the serial port
`timescale 1ns/1ps
module i2c_host_model
   import chg_stat_pkg::*;
#(
   parameter int HALF = 5
) (
   // clock
   input wire logic mclk_in,
   // serial bus, open drain data
   input wire logic sda_line_in,
   output logic scl_out,
   output logic sda_out
);
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end

   task automatic hold();
      repeat (HALF) @(posedge mclk_in);
   endtask

   // data moves one cycle after the clock fall, so it never looks like a start or stop
   task automatic bit_cycle(input logic b, output logic seen);
      @(posedge mclk_in);
      sda_out <= b;
      hold();
      scl_out <= 1'b1;
      hold();
      seen = sda_line_in;
      scl_out <= 1'b0;
   endtask

   task automatic start();
      @(posedge mclk_in);
      sda_out <= 1'b1;
      hold();
      scl_out <= 1'b1;
      hold();
      sda_out <= 1'b0;
      hold();
      scl_out <= 1'b0;
   endtask

   task automatic stop();
      @(posedge mclk_in);
      sda_out <= 1'b0;
      hold();
      scl_out <= 1'b1;
      hold();
      sda_out <= 1'b1;
      hold();
   endtask

   // a low level in the ninth slot is the target's acknowledge
   task automatic send_byte(input logic [7:0] v, output logic nak);
      logic dummy;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(v[i], dummy);
      end
      bit_cycle(1'b1, nak);
   endtask

   task automatic recv_byte(input logic last, output logic [7:0] v);
      logic dummy;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b1, v[i]);
      end
      bit_cycle(last, dummy);
   endtask

   task automatic read_regs(input logic [7:0] ptr, output logic [23:0] data,
                            output logic [2:0] naks);
      start();
      send_byte({TARGET_ADDR, 1'b0}, naks[2]);
      send_byte(ptr, naks[1]);
      start();
      send_byte({TARGET_ADDR, 1'b1}, naks[0]);
      recv_byte(1'b0, data[23:16]);
      recv_byte(1'b0, data[15:8]);
      recv_byte(1'b1, data[7:0]);
      stop();
   endtask

   task automatic write_regs(input logic [6:0] addr, input logic [7:0] ptr,
                             input logic [7:0] val, output logic [2:0] naks);
      start();
      send_byte({addr, 1'b0}, naks[2]);
      send_byte(ptr, naks[1]);
      send_byte(val, naks[0]);
      stop();
   endtask
endmodule

// ==== verification/tb.sv ====
// self-checking bench for the charger status and fault register bank
`timescale 1ns/1ps
module tb
   import chg_stat_pkg::*;
;
   logic mclk_in;
   logic reset_in;
   logic [21:0] cond_q;
   logic scl;
   logic host_sda;
   logic sda_out;
   logic sda_oe_n_out;
   wire sda_line = host_sda & (sda_oe_n_out | sda_out);
   int mismatches;
   int comparisons;
   logic [23:0] data;
   logic [23:0] exp_data;
   logic [2:0] naks;

   initial begin
      mclk_in = 1'b0;
      forever #25 mclk_in = ~mclk_in;
   end

   charger_status_fault_regs charger_status_fault_regs_inst (
      .mclk_in(mclk_in), .reset_in(reset_in), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
      .input2_blocking_fet_present_in(cond_q[0]), .input1_blocking_fet_present_in(cond_q[1]),
      .adc_conversion_done_in(cond_q[2]), .adc_one_shot_mode_in(cond_q[3]),
      .forward_mode_in(cond_q[4]), .system_floor_regulating_in(cond_q[5]),
      .fast_charge_timer_expired_in(cond_q[6]), .trickle_timer_expired_in(cond_q[7]),
      .precharge_timer_expired_in(cond_q[8]), .battery_too_low_for_source_in(cond_q[9]),
      .thermistor_cold_zone_in(cond_q[10]), .thermistor_cool_zone_in(cond_q[11]),
      .thermistor_warm_zone_in(cond_q[12]), .thermistor_hot_zone_in(cond_q[13]),
      .adapter1_overvoltage_fault_in(cond_q[14]), .adapter2_overvoltage_fault_in(cond_q[15]),
      .converter_overcurrent_fault_in(cond_q[16]), .battery_overcurrent_fault_in(cond_q[17]),
      .input_overcurrent_fault_in(cond_q[18]), .battery_overvoltage_fault_in(cond_q[19]),
      .bus_overvoltage_fault_in(cond_q[20]), .discharge_current_limiting_in(cond_q[21])
   );

   i2c_host_model i2c_host_model_inst (
      .mclk_in(mclk_in), .sda_line_in(sda_line), .scl_out(scl), .sda_out(host_sda)
   );

   // expected bytes of status three, status four and fault zero, in read order
   function automatic logic [23:0] expect_regs(input logic [21:0] c);
      logic [7:0] s3;
      logic [7:0] s4;
      s3 = {c[0], c[1], c[2] & c[3], c[5] & c[4], c[6], c[7], c[8], 1'b0};
      s4 = {3'b000, c[9], c[10], c[11], c[12], c[13]};
      return {s3, s4, c[21:14]};
   endfunction

   function automatic logic [21:0] pattern(input int i);
      if (i < 22) return 22'h1 << i;
      if (i == 22) return 22'h3FFFFF;
      if (i == 23) return 22'h00000C;
      return 22'h000030;
   endfunction

   task automatic check_bytes(input string name, input logic [23:0] exp, input logic [23:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic check_acks(input string name, input logic [2:0] exp, input logic [2:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // each read transfer takes about 650 cycles and each write about 330; the run needs about 35 transfers
   initial begin
      repeat (60000) @(posedge mclk_in);
      mismatches++;
      test_done();
   end

   initial begin
      mismatches = 0;
      comparisons = 0;
      cond_q = 22'h0;
      reset_in = 1'b1;
      repeat (16) @(posedge mclk_in);
      reset_in <= 1'b0;
      repeat (4) @(posedge mclk_in);

      i2c_host_model_inst.read_regs(OFS_STATUS_THREE, data, naks);
      check_bytes("reset values", 24'h000000, data);
      check_acks("reset read acks", 3'b000, naks);
      $display("test reset values done");

      // one condition at a time, then all of them, then the gated pairs
      for (int i = 0; i < 25; i++) begin
         @(posedge mclk_in);
         cond_q <= pattern(i);
         repeat (COND_LATENCY + 1) @(posedge mclk_in);
         exp_data = expect_regs(pattern(i));
         i2c_host_model_inst.read_regs(OFS_STATUS_THREE, data, naks);
         check_bytes("field pattern", exp_data, data);
      end
      $display("test field map done");

      // bits follow the inputs back down, and a second read sees the same
      @(posedge mclk_in);
      cond_q <= 22'h0;
      repeat (4) @(posedge mclk_in);
      i2c_host_model_inst.read_regs(OFS_STATUS_THREE, data, naks);
      check_bytes("live clear", 24'h000000, data);
      @(posedge mclk_in);
      cond_q <= 22'h2AAAAA;
      repeat (4) @(posedge mclk_in);
      i2c_host_model_inst.read_regs(OFS_STATUS_THREE, data, naks);
      check_bytes("first read", expect_regs(22'h2AAAAA), data);
      i2c_host_model_inst.read_regs(OFS_STATUS_THREE, data, naks);
      check_bytes("repeat read", expect_regs(22'h2AAAAA), data);
      $display("test live bits done");

      // writes are acknowledged but change nothing
      i2c_host_model_inst.write_regs(TARGET_ADDR, OFS_STATUS_THREE, 8'hFF, naks);
      check_acks("write acks", 3'b000, naks);
      i2c_host_model_inst.write_regs(TARGET_ADDR, OFS_FAULT_ZERO, 8'h55, naks);
      i2c_host_model_inst.read_regs(OFS_STATUS_THREE, data, naks);
      check_bytes("after writes", expect_regs(22'h2AAAAA), data);
      $display("test writes ignored done");

      // foreign address is not answered; reading past the bank gives zero
      i2c_host_model_inst.write_regs(TARGET_ADDR ^ 7'h01, OFS_STATUS_THREE, 8'hFF, naks);
      check_acks("foreign address", 3'b111, naks);
      i2c_host_model_inst.read_regs(OFS_STATUS_FOUR, data, naks);
      exp_data = expect_regs(22'h2AAAAA);
      check_bytes("read from status four", {exp_data[15:0], UNMAPPED_VALUE}, data);
      check_acks("read acks", 3'b000, naks);
      $display("test addressing done");
      test_done();
   end
endmodule
